// ---- ffm_fault_chan.sv ----
// Purpose: One fault channel: persistence delay on onset, hysteresis clear.
// Assumes: ms_tick is a one-cycle pulse once per millisecond.
// Notes:   Delay counter restarts whenever the onset condition lapses.
`timescale 1ns/1ps
module ffm_fault_chan (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ms_tick,
   input  wire logic             enable,
   input  wire logic             onset_hit,
   input  wire logic             below_clear,
   input  wire ffm_pkg::ffm_word_t delay_ms,
   output logic                  active
);
   import ffm_pkg::*;

   logic        active_q;
   logic [15:0] cnt_q;
   logic        expired;
   logic        cnt_full;

   assign expired  = (cnt_q >= delay_ms);
   assign cnt_full = (cnt_q == 16'hFFFF);
   assign active   = active_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable) begin
         active_q <= 1'b0;
         cnt_q    <= 16'h0000;
      end else if (active_q) begin
         cnt_q <= 16'h0000;
         if (below_clear) begin
            active_q <= 1'b0;
         end
      end else if (onset_hit) begin
         if (expired) begin
            active_q <= 1'b1;
         end else if (ms_tick && !cnt_full) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end else begin
         cnt_q <= 16'h0000;
      end
   end

endmodule // ffm_fault_chan

// ---- ffm_master_model.sv ----
// Purpose: Serial master stand-in issuing one holding register request at a time.
// Assumes: Answer one cycle after the taking edge.
// Notes:   Idle address lines show the inverse of the last value.
`timescale 1ns/1ps
module ffm_master_model (
   input  wire logic               core_clk,
   input  wire logic               resp_valid,
   input  wire logic               resp_err,
   input  wire ffm_pkg::ffm_word_t resp_data,
   output logic                    req_valid,
   output logic                    req_write,
   output ffm_pkg::ffm_word_t      req_addr
);
   import ffm_pkg::*;
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = 16'h0000;
   end
   // Writes are sent only to show refusal; values change via setpoints
   task automatic access(input ffm_word_t a, input logic w, output ffm_word_t d,
                         output logic e);
      int n;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_write <= ~w;
      req_addr  <= ~a;
      n = 0;
      #1;
      while (resp_valid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      d = resp_data;
      e = resp_valid ? resp_err : 1'bx;
   endtask
endmodule // ffm_master_model

// ---- ffm_pkg.sv ----
// Purpose: Shared constants and types for the filter fault monitor register bank.
// Assumes: 20 MHz core clock, holding registers addressed by offset from base 40000.
// Notes:   All register words are 16 bits wide.
package ffm_pkg;

   typedef logic [15:0] ffm_word_t;

   // Holding register base and feedback offsets
   localparam int unsigned HOLD_BASE           = 40000;
   localparam ffm_word_t OFS_FAULT_PRI        = 16'h00C8;
   localparam ffm_word_t OFS_FAULT_SEC        = 16'h00C9;
   localparam ffm_word_t OFS_FAULT_EN_PRI     = 16'h00CA;
   localparam ffm_word_t OFS_FAULT_EN_SEC     = 16'h00CB;
   localparam ffm_word_t OFS_RELAY_ACT_PRI    = 16'h00CC;
   localparam ffm_word_t OFS_RELAY_ACT_SEC    = 16'h00CD;
   localparam ffm_word_t OFS_POWER_STATUS     = 16'h00FA;
   localparam ffm_word_t OFS_FAULTED_STATUS   = 16'h00FB;
   localparam ffm_word_t OFS_RATED_VOLTAGE    = 16'h0104;
   localparam ffm_word_t OFS_RATED_FREQUENCY  = 16'h0106;
   localparam ffm_word_t OFS_LINK_NODE_ADDR   = 16'h012C;
   localparam ffm_word_t OFS_LINK_BIT_RATE    = 16'h012D;
   localparam ffm_word_t OFS_LINK_PARITY      = 16'h012E;
   localparam ffm_word_t OFS_RELAY_CLOSE_DLY  = 16'h0140;
   localparam ffm_word_t OFS_RELAY_OPEN_DLY   = 16'h0141;
   localparam ffm_word_t OFS_OVERVOLT_ONSET   = 16'h0142;
   localparam ffm_word_t OFS_OVERVOLT_CLEAR   = 16'h0143;
   localparam ffm_word_t OFS_OVERVOLT_DELAY   = 16'h0144;
   localparam ffm_word_t OFS_OVERFREQ_ONSET   = 16'h0145;
   localparam ffm_word_t OFS_OVERFREQ_CLEAR   = 16'h0146;
   localparam ffm_word_t OFS_OVERFREQ_DELAY   = 16'h0147;

   // Primary fault word bit positions
   localparam int unsigned BIT_OV_A  = 1;
   localparam int unsigned BIT_OV_B  = 2;
   localparam int unsigned BIT_OV_C  = 3;
   localparam int unsigned BIT_HF_AB = 4;
   localparam int unsigned BIT_HF_BC = 5;
   localparam int unsigned BIT_HF_CA = 6;

   // Status word values
   localparam ffm_word_t STAT_OFF    = 16'h0000;
   localparam ffm_word_t STAT_ON     = 16'h0001;
   localparam ffm_word_t WORD_ZERO   = 16'h0000;

   // Scaling: percent base and maximum output fundamental in Hz
   localparam logic [31:0] PCT_BASE     = 32'h0000_0064;
   localparam logic [15:0] MAX_FREQ_HZ  = 16'h01F4;

   // Timing: one millisecond at the core clock
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

endpackage : ffm_pkg

// ---- ffm_regs.sv ----
// Purpose: Feedback holding registers and fault relay control of a filter monitor.
// Assumes: Setpoints and measurements arrive on core_clk; power sense is a raw pin.
// Notes:   Requests come from the serial slave framing logic, one per cycle at most.
//
// Summary of operation
// - Relay energizes only for active enabled faults.
// - One mask bit per fault condition.
// - Power status reads 0 off, 1 on.
// - Faulted status reads 0 normal, 1 faulted.
// - Relay close delay after declared fault.
// - Relay opens after all clear plus delay.
// - Overvoltage onset as percent of rated voltage.
// - High frequency onset as percent of maximum.
// - Fault detection delays counted in milliseconds.
// - Separate clear threshold gives hysteresis.
// - Feedback registers are read-only; writes refused.
// - Signed 16-bit words at holding offsets.
// - Primary bits 1-3 overvoltage, 4-6 high frequency.
`timescale 1ns/1ps
module ffm_regs #(
   parameter int unsigned MS_CYC = ffm_pkg::MS_CYCLES
) (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic               req_valid,
   input  wire logic               req_write,
   input  wire ffm_pkg::ffm_word_t req_addr,
   output logic                    resp_valid,
   output logic                    resp_err,
   output ffm_pkg::ffm_word_t      resp_data,
   input  wire logic               power_sense,
   input  wire ffm_pkg::ffm_word_t volt_a,
   input  wire ffm_pkg::ffm_word_t volt_b,
   input  wire ffm_pkg::ffm_word_t volt_c,
   input  wire ffm_pkg::ffm_word_t freq_ab,
   input  wire ffm_pkg::ffm_word_t freq_bc,
   input  wire ffm_pkg::ffm_word_t freq_ca,
   input  wire ffm_pkg::ffm_word_t sp_fault_enable_primary,
   input  wire ffm_pkg::ffm_word_t sp_fault_enable_secondary,
   input  wire ffm_pkg::ffm_word_t sp_relay_action_primary,
   input  wire ffm_pkg::ffm_word_t sp_relay_action_secondary,
   input  wire ffm_pkg::ffm_word_t sp_rated_voltage,
   input  wire ffm_pkg::ffm_word_t sp_rated_frequency,
   input  wire ffm_pkg::ffm_word_t sp_link_node_address,
   input  wire ffm_pkg::ffm_word_t sp_link_bit_rate,
   input  wire ffm_pkg::ffm_word_t sp_link_parity,
   input  wire ffm_pkg::ffm_word_t sp_relay_close_delay,
   input  wire ffm_pkg::ffm_word_t sp_relay_open_delay,
   input  wire ffm_pkg::ffm_word_t sp_overvolt_onset,
   input  wire ffm_pkg::ffm_word_t sp_overvolt_clear,
   input  wire ffm_pkg::ffm_word_t sp_overvolt_delay,
   input  wire ffm_pkg::ffm_word_t sp_overfreq_onset,
   input  wire ffm_pkg::ffm_word_t sp_overfreq_clear,
   input  wire ffm_pkg::ffm_word_t sp_overfreq_delay,
   output logic                    relay_energize,
   output logic                    fault_any
);
   import ffm_pkg::*;

   // Relay sequencing states
   typedef enum logic [3:0] {
      RLY_IDLE  = 4'b0001,
      RLY_CLOSE = 4'b0010,
      RLY_ON    = 4'b0100,
      RLY_OPEN  = 4'b1000
   } ffm_relay_t;

   // Measured value above a percentage of a reference; negatives count as zero
   function automatic logic pct_above(input ffm_word_t meas, input ffm_word_t ref_val,
                                      input ffm_word_t pct);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'h0000_0000;
      rhs = 32'h0000_0000;
      if (!meas[15]) begin
         lhs = {16'h0000, meas} * PCT_BASE;
      end
      rhs = {16'h0000, ref_val} * {16'h0000, pct};
      return lhs > rhs;
   endfunction

   // Measured value below a percentage of a reference
   function automatic logic pct_below(input ffm_word_t meas, input ffm_word_t ref_val,
                                      input ffm_word_t pct);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'h0000_0000;
      rhs = 32'h0000_0000;
      if (!meas[15]) begin
         lhs = {16'h0000, meas} * PCT_BASE;
      end
      rhs = {16'h0000, ref_val} * {16'h0000, pct};
      return lhs < rhs;
   endfunction

   localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);

   // Millisecond enable
   logic [15:0] ms_cnt_q;
   logic        ms_tick_q;
   logic        ms_wrap;

   assign ms_wrap = (ms_cnt_q >= MS_LAST);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ms_cnt_q  <= 16'h0000;
         ms_tick_q <= 1'b0;
      end else if (ms_wrap) begin
         ms_cnt_q  <= 16'h0000;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q  <= ms_cnt_q + 16'h0001;
         ms_tick_q <= 1'b0;
      end
   end

   // Power sense pin synchroniser and qualifier
   logic pwr_s1_q;
   logic pwr_s2_q;
   logic pwr_s3_q;
   logic pwr_on_q;
   logic pwr_agree;

   assign pwr_agree = (pwr_s2_q == pwr_s3_q);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pwr_s1_q <= 1'b0;
         pwr_s2_q <= 1'b0;
         pwr_s3_q <= 1'b0;
         pwr_on_q <= 1'b0;
      end else begin
         pwr_s1_q <= power_sense;
         pwr_s2_q <= pwr_s1_q;
         pwr_s3_q <= pwr_s2_q;
         if (pwr_agree) begin
            pwr_on_q <= pwr_s3_q;
         end
      end
   end

   // Fault channels: three overvoltage, three high frequency
   ffm_word_t   meas [6];
   ffm_word_t   refv [6];
   ffm_word_t   onset_pct [6];
   ffm_word_t   clear_pct [6];
   ffm_word_t   dly [6];
   logic [5:0]  chan_en;
   logic [5:0]  chan_onset;
   logic [5:0]  chan_clear;
   logic [5:0]  chan_active;

   assign meas[0] = volt_a;
   assign meas[1] = volt_b;
   assign meas[2] = volt_c;
   assign meas[3] = freq_ab;
   assign meas[4] = freq_bc;
   assign meas[5] = freq_ca;

   assign chan_en = sp_fault_enable_primary[BIT_HF_CA:BIT_OV_A];

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_chan
         if (gi < 3) begin : g_ov
            assign refv[gi]      = sp_rated_voltage;
            assign onset_pct[gi] = sp_overvolt_onset;
            assign clear_pct[gi] = sp_overvolt_clear;
            assign dly[gi]       = sp_overvolt_delay;
         end else begin : g_hf
            assign refv[gi]      = MAX_FREQ_HZ;
            assign onset_pct[gi] = sp_overfreq_onset;
            assign clear_pct[gi] = sp_overfreq_clear;
            assign dly[gi]       = sp_overfreq_delay;
         end
         assign chan_onset[gi] = pct_above(meas[gi], refv[gi], onset_pct[gi]);
         assign chan_clear[gi] = pct_below(meas[gi], refv[gi], clear_pct[gi]);

         ffm_fault_chan u_chan (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .ms_tick     (ms_tick_q),
            .enable      (chan_en[gi]),
            .onset_hit   (chan_onset[gi]),
            .below_clear (chan_clear[gi]),
            .delay_ms    (dly[gi]),
            .active      (chan_active[gi])
         );
      end
   endgenerate

   // Fault words
   ffm_word_t fault_pri;
   ffm_word_t fault_sec;
   ffm_word_t gate_pri;
   ffm_word_t gate_sec;
   logic      relay_demand;

   assign fault_pri = {9'h000, chan_active, 1'b0};
   assign fault_sec = WORD_ZERO;
   assign fault_any = |fault_pri || |fault_sec;

   // Relay wanted for any active fault whose enable and action bits are both set
   assign gate_pri     = fault_pri & sp_fault_enable_primary & sp_relay_action_primary;
   assign gate_sec     = fault_sec & sp_fault_enable_secondary & sp_relay_action_secondary;
   assign relay_demand = |gate_pri || |gate_sec;

   // Relay sequencing
   ffm_relay_t  rly_q;
   ffm_relay_t  rly_d;
   logic [15:0] rly_cnt_q;
   logic [15:0] rly_cnt_d;
   logic        close_done;
   logic        open_done;

   assign close_done = (rly_cnt_q >= sp_relay_close_delay);
   assign open_done  = (rly_cnt_q >= sp_relay_open_delay);

   always_comb begin
      rly_d     = rly_q;
      rly_cnt_d = rly_cnt_q;
      case (rly_q)
         RLY_IDLE: begin
            rly_cnt_d = 16'h0000;
            if (relay_demand) begin
               rly_d = RLY_CLOSE;
            end
         end
         RLY_CLOSE: begin
            if (!relay_demand) begin
               rly_d     = RLY_IDLE;
               rly_cnt_d = 16'h0000;
            end else if (close_done) begin
               rly_d     = RLY_ON;
               rly_cnt_d = 16'h0000;
            end else if (ms_tick_q) begin
               rly_cnt_d = rly_cnt_q + 16'h0001;
            end
         end
         RLY_ON: begin
            rly_cnt_d = 16'h0000;
            if (!relay_demand) begin
               rly_d = RLY_OPEN;
            end
         end
         RLY_OPEN: begin
            if (relay_demand) begin
               rly_d     = RLY_ON;
               rly_cnt_d = 16'h0000;
            end else if (open_done) begin
               rly_d     = RLY_IDLE;
               rly_cnt_d = 16'h0000;
            end else if (ms_tick_q) begin
               rly_cnt_d = rly_cnt_q + 16'h0001;
            end
         end
         default: begin
            rly_d     = RLY_IDLE;
            rly_cnt_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rly_q     <= RLY_IDLE;
         rly_cnt_q <= 16'h0000;
      end else begin
         rly_q     <= rly_d;
         rly_cnt_q <= rly_cnt_d;
      end
   end

   assign relay_energize = (rly_q == RLY_ON) || (rly_q == RLY_OPEN);

   // Holding register read decode
   ffm_word_t rd_word;
   logic      rd_hit;
   ffm_word_t pwr_word;
   ffm_word_t flt_word;

   assign pwr_word = pwr_on_q ? STAT_ON : STAT_OFF;
   assign flt_word = fault_any ? STAT_ON : STAT_OFF;

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = WORD_ZERO;
      case (req_addr)
         OFS_FAULT_PRI:       rd_word = fault_pri;
         OFS_FAULT_SEC:       rd_word = fault_sec;
         OFS_FAULT_EN_PRI:    rd_word = sp_fault_enable_primary;
         OFS_FAULT_EN_SEC:    rd_word = sp_fault_enable_secondary;
         OFS_RELAY_ACT_PRI:   rd_word = sp_relay_action_primary;
         OFS_RELAY_ACT_SEC:   rd_word = sp_relay_action_secondary;
         OFS_POWER_STATUS:    rd_word = pwr_word;
         OFS_FAULTED_STATUS:  rd_word = flt_word;
         OFS_RATED_VOLTAGE:   rd_word = sp_rated_voltage;
         OFS_RATED_FREQUENCY: rd_word = sp_rated_frequency;
         OFS_LINK_NODE_ADDR:  rd_word = sp_link_node_address;
         OFS_LINK_BIT_RATE:   rd_word = sp_link_bit_rate;
         OFS_LINK_PARITY:     rd_word = sp_link_parity;
         OFS_RELAY_CLOSE_DLY: rd_word = sp_relay_close_delay;
         OFS_RELAY_OPEN_DLY:  rd_word = sp_relay_open_delay;
         OFS_OVERVOLT_ONSET:  rd_word = sp_overvolt_onset;
         OFS_OVERVOLT_CLEAR:  rd_word = sp_overvolt_clear;
         OFS_OVERVOLT_DELAY:  rd_word = sp_overvolt_delay;
         OFS_OVERFREQ_ONSET:  rd_word = sp_overfreq_onset;
         OFS_OVERFREQ_CLEAR:  rd_word = sp_overfreq_clear;
         OFS_OVERFREQ_DELAY:  rd_word = sp_overfreq_delay;
         default:             rd_hit  = 1'b0;
      endcase
   end

   // Response: data on hit, error on unmapped offset or any write
   logic      resp_valid_q;
   logic      resp_err_q;
   ffm_word_t resp_data_q;
   logic      refuse;
   ffm_word_t resp_word;

   assign refuse    = req_write || !rd_hit;
   assign resp_word = refuse ? WORD_ZERO : rd_word;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         resp_valid_q <= 1'b0;
         resp_err_q   <= 1'b0;
         resp_data_q  <= WORD_ZERO;
      end else begin
         resp_valid_q <= req_valid;
         resp_err_q   <= req_valid && refuse;
         if (req_valid) begin
            resp_data_q <= resp_word;
         end
      end
   end

   assign resp_valid = resp_valid_q;
   assign resp_err   = resp_err_q;
   assign resp_data  = resp_data_q;

endmodule // ffm_regs

// ---- ffm_regs_asserts.sv ----
// Purpose: Port checker for the feedback register bank and relay.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to ffm_regs below the module.
`timescale 1ns/1ps
module ffm_regs_asserts #(
   parameter int unsigned MS_CYC = 4
) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               req_valid,
   input wire logic               req_write,
   input wire ffm_pkg::ffm_word_t req_addr,
   input wire logic               resp_valid,
   input wire logic               resp_err,
   input wire ffm_pkg::ffm_word_t resp_data,
   input wire logic               relay_energize,
   input wire logic               fault_any
);
   import ffm_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire rd = req_valid && !req_write;
   property p_wr_refused;
      req_valid && req_write |=> resp_valid && resp_err && resp_data == 16'h0000;
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("write not refused");
   property p_answer;
      req_valid |=> resp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_no_answer;
      !req_valid |=> !resp_valid;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("stray answer");
   property p_unmapped;
      rd && req_addr == 16'h00CE |=> resp_err && resp_data == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   property p_power;
      rd && req_addr == OFS_POWER_STATUS |=> !resp_err && resp_data[15:1] == 15'h0000;
   endproperty
   a_power: assert property (p_power) else $error("power word bad");
   property p_faulted;
      rd && req_addr == OFS_FAULTED_STATUS |=> resp_data == {15'h0000, $past(fault_any)};
   endproperty
   a_faulted: assert property (p_faulted) else $error("faulted word bad");
   property p_fault_bits;
      rd && req_addr == OFS_FAULT_PRI |=> resp_data[0] == 1'b0 && resp_data[15:7] == 9'h000;
   endproperty
   a_fault_bits: assert property (p_fault_bits) else $error("fault word bits bad");
   property p_relay_cause;
      $rose(relay_energize) |-> $past(fault_any);
   endproperty
   a_relay_cause: assert property (p_relay_cause) else $error("relay without fault");
   property p_close_wait;
      $rose(fault_any) |-> !$rose(relay_energize) ##1 !$rose(relay_energize);
   endproperty
   a_close_wait: assert property (p_close_wait) else $error("relay too early");
   property p_open_wait;
      $fell(fault_any) && $past(relay_energize) |-> relay_energize;
   endproperty
   a_open_wait: assert property (p_open_wait) else $error("relay released early");
endmodule // ffm_regs_asserts

bind ffm_regs ffm_regs_asserts #(.MS_CYC(MS_CYC)) chk_u (
   .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
   .req_addr(req_addr), .resp_valid(resp_valid), .resp_err(resp_err),
   .resp_data(resp_data), .relay_energize(relay_energize), .fault_any(fault_any));

// ---- ffm_regs_tb.sv ----
// Purpose: Self-checking bench for the feedback register bank.
// Assumes: Short millisecond via MS_CYC.
// Notes:   Expected words come from a bench model of the map.
`timescale 1ns/1ps
module ffm_regs_tb;
   import ffm_pkg::*;
   localparam int MS = 4;
   logic core_clk, rst_n, power_sense, req_valid, req_write, resp_valid, resp_err;
   logic relay_energize, fault_any;
   ffm_word_t req_addr, resp_data;
   ffm_word_t meas [6];
   ffm_word_t sp [17];
   ffm_word_t ofs [17] = '{16'h00CA, 16'h00CB, 16'h00CC, 16'h00CD, 16'h0104, 16'h0106,
      16'h012C, 16'h012D, 16'h012E, 16'h0140, 16'h0141, 16'h0142, 16'h0143, 16'h0144,
      16'h0145, 16'h0146, 16'h0147};
   int fails, samples_checked, cycles, mdl_fault;
   logic [31:0] rnd = 32'h7A513956;
   ffm_regs #(.MS_CYC(MS)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .resp_valid(resp_valid), .resp_err(resp_err),
      .resp_data(resp_data), .power_sense(power_sense), .volt_a(meas[0]),
      .volt_b(meas[1]), .volt_c(meas[2]), .freq_ab(meas[3]), .freq_bc(meas[4]),
      .freq_ca(meas[5]), .sp_fault_enable_primary(sp[0]), .sp_fault_enable_secondary(sp[1]),
      .sp_relay_action_primary(sp[2]), .sp_relay_action_secondary(sp[3]),
      .sp_rated_voltage(sp[4]), .sp_rated_frequency(sp[5]), .sp_link_node_address(sp[6]),
      .sp_link_bit_rate(sp[7]), .sp_link_parity(sp[8]), .sp_relay_close_delay(sp[9]),
      .sp_relay_open_delay(sp[10]), .sp_overvolt_onset(sp[11]), .sp_overvolt_clear(sp[12]),
      .sp_overvolt_delay(sp[13]), .sp_overfreq_onset(sp[14]), .sp_overfreq_clear(sp[15]),
      .sp_overfreq_delay(sp[16]), .relay_energize(relay_energize), .fault_any(fault_any));
   ffm_master_model mst_u (
      .core_clk(core_clk), .resp_valid(resp_valid), .resp_err(resp_err),
      .resp_data(resp_data), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic ffm_word_t mdl(input ffm_word_t a);
      for (int i = 0; i < 17; i++) if (ofs[i] == a) return sp[i];
      if (a == OFS_FAULT_PRI) return ffm_word_t'(mdl_fault);
      if (a == OFS_POWER_STATUS) return {15'h0000, power_sense};
      if (a == OFS_FAULTED_STATUS) return (mdl_fault != 0) ? 16'h0001 : 16'h0000;
      return 16'h0000;
   endfunction
   // Level in 0.1 V or Hz that meets a percent threshold exactly
   function automatic int lim(input int i, input int sel);
      int base;
      base = (i < 3) ? int'(sp[4]) : 500;
      return base * int'(sp[(i < 3 ? 11 : 14) + sel]) / 100;
   endfunction
   task automatic end_sim();
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input ffm_word_t a, input logic w, input logic xe, input ffm_word_t xd);
      ffm_word_t d;
      logic e;
      mst_u.access(a, w, d, e);
      samples_checked++;
      if (e !== xe || d !== xd) begin
         fails++;
         $display("wrong value %0t addr %h got %h err %b", $time, a, d, e);
      end
   endtask
   task automatic chk_b(input logic got, input logic x);
      samples_checked++;
      if (got !== x) begin
         fails++;
         $display("wrong value %0t flag %b", $time, got);
      end
   endtask
   task automatic win(input logic rly, input logic lvl, input int lo, input int hi_c);
      int n;
      n = 0;
      while ((rly ? relay_energize : fault_any) !== lvl && n <= hi_c) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      samples_checked++;
      if (n < lo || n > hi_c) begin
         fails++;
         $display("wrong value %0t wait %0d cycles", $time, n);
      end
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      rst_n = 1'b0;
      power_sense = 1'b1;
      foreach (meas[i]) meas[i] = 16'h0000;
      foreach (sp[i]) begin
         rnd = lfsr(rnd);
         sp[i] = rnd[15:0];
      end
      sp[0] = 16'hFFFF;
      sp[2] = 16'h007E;
      sp[4] = 16'h12C0;
      sp[9] = 16'h0002;
      sp[10] = 16'h0002;
      sp[11] = 16'h007D;
      sp[12] = 16'h006E;
      sp[13] = 16'h0003;
      sp[14] = 16'h007D;
      sp[15] = 16'h006E;
      sp[16] = 16'h0003;
      mdl_fault = 0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) begin
         chk(ofs[i], 1'b1, 1'b1, 16'h0000);
         chk(ofs[i], 1'b0, 1'b0, mdl(ofs[i]));
      end
      chk(OFS_FAULT_SEC, 1'b0, 1'b0, 16'h0000);
      chk(OFS_POWER_STATUS, 1'b0, 1'b0, mdl(OFS_POWER_STATUS));
      chk(OFS_FAULTED_STATUS, 1'b0, 1'b0, mdl(OFS_FAULTED_STATUS));
      chk(16'h00CE, 1'b0, 1'b1, 16'h0000);
      chk(16'h0000, 1'b0, 1'b1, 16'h0000);
      @(posedge core_clk) meas[0] <= ffm_word_t'(lim(0, 0));
      repeat (6 * MS) @(posedge core_clk);
      meas[0] <= ffm_word_t'(lim(0, 0) + 1);
      repeat (MS) @(posedge core_clk);
      meas[0] <= 16'h0000;
      repeat (6 * MS) @(posedge core_clk);
      chk(OFS_FAULT_PRI, 1'b0, 1'b0, mdl(OFS_FAULT_PRI));
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk) meas[i] <= ffm_word_t'(lim(i, 0) + 1);
         win(1'b0, 1'b1, 2 * MS, 4 * MS + 4);
         mdl_fault = 1 << (i + 1);
         chk(OFS_FAULT_PRI, 1'b0, 1'b0, mdl(OFS_FAULT_PRI));
         chk(OFS_FAULTED_STATUS, 1'b0, 1'b0, mdl(OFS_FAULTED_STATUS));
         win(1'b1, 1'b1, 1, 3 * MS + 4);
         meas[i] <= ffm_word_t'(lim(i, 1));
         repeat (3 * MS) @(posedge core_clk);
         #1 chk_b(fault_any, 1'b1);
         @(posedge core_clk) meas[i] <= ffm_word_t'(lim(i, 1) - 1);
         win(1'b0, 1'b0, 0, 4);
         chk_b(relay_energize, 1'b1);
         win(1'b1, 1'b0, MS, 3 * MS + 4);
         mdl_fault = 0;
         chk(OFS_FAULT_PRI, 1'b0, 1'b0, mdl(OFS_FAULT_PRI));
      end
      @(posedge core_clk) sp[2] <= 16'h0000;
      meas[3] <= ffm_word_t'(lim(3, 0) + 1);
      win(1'b0, 1'b1, 2 * MS, 4 * MS + 4);
      repeat (5 * MS) @(posedge core_clk);
      #1 chk_b(relay_energize, 1'b0);
      @(posedge core_clk) sp[0] <= 16'hFFEF;
      win(1'b0, 1'b0, 0, 3);
      chk(OFS_FAULT_PRI, 1'b0, 1'b0, mdl(OFS_FAULT_PRI));
      @(posedge core_clk) power_sense <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(OFS_POWER_STATUS, 1'b0, 1'b0, mdl(OFS_POWER_STATUS));
      end_sim();
   end
endmodule // ffm_regs_tb
